// [src/comparator_cfg.svh]
/*
 Register offsets, field positions and reset values of the comparator control block.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH

`define STATUS_OFS        8'h00
`define CTRL1_OFS         8'h10
`define CTRL2_OFS         8'h20
`define DACCTRL_OFS       8'h30
`define ALIAS_CLR         2'h1
`define ALIAS_SET         2'h2
`define ALIAS_INV         2'h3

`define CTL_ON_POS        15
`define CTL_OE_POS        14
`define CTL_POL_POS       13
`define CTL_EVT_POS       9
`define CTL_OUT_POS       8
`define CTL_EDGE_POS      6
`define CTL_PREF_POS      4
`define CTL_NSEL_POS      0
`define CTL_WMASK         32'h0000_E0D3

`define ST_EVT_POS        16
`define ST_REFSRC_POS     8
`define ST_WMASK          32'h0000_0100

`define DAC_CODE_POS      16
`define DAC_WMASK         32'h001F_0000

`define CTRL_RESET        32'h0000_0000
`define STATUS_RESET      32'h0000_0000
`define DAC_RESET         32'h0000_0000

`endif

// [src/comparator_pkg.sv]
/*
 Types shared by the comparator control block.
 Assumes comparator_cfg.svh for numeric constants.
*/
package comparator_pkg;
    typedef enum logic [1:0]
    {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_ANY  = 2'h3
    } edge_sel_t;

    typedef enum logic [1:0]
    {
        NEG_PIN_B = 2'h0,
        NEG_PIN_C = 2'h1,
        NEG_PIN_D = 2'h2,
        NEG_BANDGAP = 2'h3
    } neg_sel_t;

    typedef logic [31:0] word_t;
    typedef logic [7:0]  addr_t;
endpackage

// [src/comparator_channel.sv]
/*
 One comparator channel: result synchroniser, polarity,
 edge event detection and sticky event flag.
 Assumes the raw analog compare result arrives asynchronously.
*/
`timescale 1ns/10ps
`include "comparator_cfg.svh"
module comparator_channel
    import comparator_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst,
    input  wire logic      clkEn,
    input  wire logic      enable,
    input  wire logic      outInvert,
    input  wire edge_sel_t edgeSelect,
    input  wire logic      rawResult,
    input  wire logic      evtWrite,
    input  wire logic      evtWriteVal,
    output logic           result,
    output logic           eventFlag,
    output logic           trigger
);
    logic [2:0] sync_q, sync_d;
    logic       agreed_q, agreed_d;
    logic       prev_q, prev_d;
    logic       evt_q, evt_d;
    logic       trig_q, trig_d;
    logic       rise, fall, hit;

    // Synchroniser, edge detection and event flag
    always_comb
    begin
        sync_d   = {sync_q[1:0], rawResult};
        agreed_d = agreed_q;
        if (sync_q[2] == sync_q[1])
            agreed_d = sync_q[1] ^ outInvert;
        if (!enable)
            agreed_d = 1'b0;
        prev_d = agreed_q;
        rise   = agreed_q & ~prev_q;
        fall   = ~agreed_q & prev_q;
        // Inverted cases swap rise and fall of the polarity-adjusted output
        case (edgeSelect)
            EDGE_RISE: hit = outInvert ? fall : rise;
            EDGE_FALL: hit = outInvert ? rise : fall;
            EDGE_ANY:  hit = rise | fall;
            default:   hit = 1'b0;
        endcase
        hit    = hit & enable & ~evt_q;
        trig_d = hit;
        evt_d  = evt_q;
        if (evtWrite)
            evt_d = evtWriteVal;
        if (hit)
            evt_d = 1'b1;
        if (!enable)
            evt_d = 1'b0;
    end

    // State registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync_q   <= 3'h0;
            agreed_q <= 1'b0;
            prev_q   <= 1'b0;
            evt_q    <= 1'b0;
            trig_q   <= 1'b0;
        end
        else if (clkEn)
        begin
            sync_q   <= sync_d;
            agreed_q <= agreed_d;
            prev_q   <= prev_d;
            evt_q    <= evt_d;
            trig_q   <= trig_d;
        end
    end

    assign result    = agreed_q;
    assign eventFlag = evt_q;
    assign trigger   = trig_q;
endmodule

// [src/reference_dac.sv]
/*
 Reference DAC code register stage and internal reference source choice.
 Assumes the analog DAC converts the five-bit code outside this logic.
*/
`timescale 1ns/10ps
`include "comparator_cfg.svh"
module reference_dac
#(
    parameter int CODE_W = 5
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic [CODE_W-1:0] codeIn,
    input  wire logic              useExternal,
    output logic      [CODE_W-1:0] dacCode,
    output logic                   selExternal
);
    initial
    begin
        if (CODE_W != 5)
            $error("reference_dac: code width must be 5 for 32 levels");
    end

    logic [CODE_W-1:0] code_q, code_d;
    logic              ext_q, ext_d;

    // Level code and reference source
    always_comb
    begin
        code_d = codeIn;
        ext_d  = useExternal;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            code_q <= '0;
            ext_q  <= 1'b0;
        end
        else if (clkEn)
        begin
            code_q <= code_d;
            ext_q  <= ext_d;
        end
    end

    assign dacCode     = code_q;
    assign selExternal = ext_q;
endmodule

// [src/comparator_control.sv]
/*
 Control and event logic for two comparators with module status and DAC code
 registers, reached over a plain register port with clear/set/invert aliases.
 Assumes analog comparators, muxes and the DAC sit outside and use the selects.
*/
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "comparator_cfg.svh"
// How it works
// - Comparator runs only while its enable bit is one.
// - Output pin enable drives the result onto the result pin while both it and the comparator enable bit are one.
// - Invert bit inverts the comparator output.
// - Selected event sets sticky flag; further events suppressed while set.
// - Edge code 11 flags any output change.
// - Edge code 10 flags falling, or rising when inverted.
// - Edge code 01 flags rising, or falling when inverted.
// - Edge code 00 raises nothing.
// - Positive select picks internal reference when one, pin A when zero.
// - Negative select 11 picks the band gap.
// - Negative select 10 pin D, 01 pin C, 00 pin B.
// - Unimplemented bits read zero.
// - Reference DAC offers 32 levels via five-bit code.
// - DAC output feeds comparators internally without a pin.
// - Alias offsets 4, 8, C clear, set, invert written ones.
// - Module source bit picks external pin when one, DAC when zero.
// - Module status mirrors each event flag and result bit.
module comparator_control
    import comparator_pkg::*;
#(
    parameter int CHANNELS = 2
)
(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                clkEn,
    input  wire comparator_pkg::addr_t regAddr,
    input  wire comparator_pkg::word_t regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output comparator_pkg::word_t    regRdata,
    input  wire logic [CHANNELS-1:0] rawResult,
    output logic [CHANNELS-1:0]      resultPin,
    output logic [CHANNELS-1:0]      resultPinOe,
    output logic [CHANNELS-1:0]      compEnable,
    output logic [CHANNELS-1:0]      posInternal,
    output logic [2*CHANNELS-1:0]    negSelect,
    output logic [CHANNELS-1:0]      trigger,
    output logic [4:0]               dacCode,
    output logic                     refExternal
);
    import comparator_pkg::*;

    initial
    begin
        if (CHANNELS != 2)
            $error("comparator_control: exactly two channels supported");
    end

    word_t             ctrl_q [CHANNELS];
    word_t             ctrl_d [CHANNELS];
    word_t             stat_q, stat_d;
    word_t             dac_q, dac_d;
    word_t             rd_q, rd_d;
    logic [CHANNELS-1:0] pin_q, pin_d, oe_q, oe_d;
    logic [CHANNELS-1:0] res, evt, trg, evtWr, evtVal;
    logic [1:0]          alias_a;
    logic [5:0]          base_a;

    assign alias_a = regAddr[3:2];
    assign base_a  = {regAddr[7:4], 2'b00};

    // Apply a write through plain or alias address
    function automatic word_t apply(input word_t old, input word_t wd, input logic [1:0] al,
                                    input word_t mask);
        word_t nv;
        case (al)
            `ALIAS_CLR: nv = old & ~wd;
            `ALIAS_SET: nv = old | wd;
            `ALIAS_INV: nv = old ^ wd;
            default:    nv = wd;
        endcase
        return (nv & mask) | (old & ~mask);
    endfunction

    // Per-channel control registers and channel logic
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : ch
            logic  hit;
            word_t nv;
            assign hit = regWr && ({base_a, 2'b00} ==
                         (g == 0 ? `CTRL1_OFS : `CTRL2_OFS));
            always_comb
            begin
                ctrl_d[g] = ctrl_q[g];
                nv        = apply(ctrl_q[g], regWdata, alias_a, `CTL_WMASK | 32'h0000_0200);
                evtWr[g]  = hit;
                evtVal[g] = nv[`CTL_EVT_POS];
                if (hit)
                    ctrl_d[g] = nv & `CTL_WMASK;
            end
            comparator_channel u_chan
            (
                .ref_clk     (ref_clk),
                .rst         (rst),
                .clkEn       (clkEn),
                .enable      (ctrl_q[g][`CTL_ON_POS]),
                .outInvert   (ctrl_q[g][`CTL_POL_POS]),
                .edgeSelect  (edge_sel_t'(ctrl_q[g][`CTL_EDGE_POS +: 2])),
                .rawResult   (rawResult[g]),
                .evtWrite    (evtWr[g]),
                .evtWriteVal (evtVal[g]),
                .result      (res[g]),
                .eventFlag   (evt[g]),
                .trigger     (trg[g])
            );
            assign compEnable[g]        = ctrl_q[g][`CTL_ON_POS];
            assign posInternal[g]       = ctrl_q[g][`CTL_PREF_POS];
            assign negSelect[2*g +: 2]  = ctrl_q[g][`CTL_NSEL_POS +: 2];
        end
    endgenerate

    // Pin drive: output enable gates the result onto the pin
    always_comb
    begin
        for (int i = 0; i < CHANNELS; i++)
        begin
            // Next control value keeps the pin enable in step with the enable output
            oe_d[i]  = ctrl_d[i][`CTL_OE_POS] & ctrl_d[i][`CTL_ON_POS];
            pin_d[i] = oe_d[i] & res[i];
        end
    end

    // Module status and DAC register writes
    always_comb
    begin
        stat_d = stat_q;
        dac_d  = dac_q;
        if (regWr && {base_a, 2'b00} == `STATUS_OFS)
            stat_d = apply(stat_q, regWdata, alias_a, `ST_WMASK) & `ST_WMASK;
        else if (regWr && {base_a, 2'b00} == `DACCTRL_OFS)
            dac_d = apply(dac_q, regWdata, alias_a, `DAC_WMASK) & `DAC_WMASK;
    end

    // Read mux, unmapped and unimplemented bits return zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (regRd)
        begin
            if ({base_a, 2'b00} == `STATUS_OFS)
                rd_d = stat_q | ({30'h0, evt} << `ST_EVT_POS) | {30'h0, res};
            else if ({base_a, 2'b00} == `CTRL1_OFS)
                rd_d = ctrl_q[0] | ({31'h0, evt[0]} << `CTL_EVT_POS)
                     | ({31'h0, res[0]} << `CTL_OUT_POS);
            else if ({base_a, 2'b00} == `CTRL2_OFS)
                rd_d = ctrl_q[1] | ({31'h0, evt[1]} << `CTL_EVT_POS)
                     | ({31'h0, res[1]} << `CTL_OUT_POS);
            else if ({base_a, 2'b00} == `DACCTRL_OFS)
                rd_d = dac_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < CHANNELS; i++)
                ctrl_q[i] <= `CTRL_RESET;
            stat_q <= `STATUS_RESET;
            dac_q  <= `DAC_RESET;
            rd_q   <= 32'h0000_0000;
            pin_q  <= '0;
            oe_q   <= '0;
        end
        else if (clkEn)
        begin
            for (int i = 0; i < CHANNELS; i++)
                ctrl_q[i] <= ctrl_d[i];
            stat_q <= stat_d;
            dac_q  <= dac_d;
            rd_q   <= rd_d;
            pin_q  <= pin_d;
            oe_q   <= oe_d;
        end
    end

    reference_dac u_dac
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .clkEn       (clkEn),
        .codeIn      (dac_q[`DAC_CODE_POS +: 5]),
        .useExternal (stat_q[`ST_REFSRC_POS]),
        .dacCode     (dacCode),
        .selExternal (refExternal)
    );

    assign regRdata    = rd_q;
    assign resultPin   = pin_q;
    assign resultPinOe = oe_q;
    assign trigger     = trg;
endmodule

// [sim/comparator_control_properties.sv]
/*
 Port assertions for the comparator control block.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module comparator_control_properties
    import comparator_pkg::*;
#(
    parameter int CHANNELS = 2
)
(
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  regWr,
    input wire logic                  regRd,
    input wire comparator_pkg::word_t regRdata,
    input wire logic [CHANNELS-1:0]   resultPin,
    input wire logic [CHANNELS-1:0]   resultPinOe,
    input wire logic [CHANNELS-1:0]   compEnable,
    input wire logic [2*CHANNELS-1:0] negSelect,
    input wire logic [CHANNELS-1:0]   trigger,
    input wire logic [4:0]            dacCode,
    input wire logic                  refExternal
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Read data only in its slot, upper bits always empty
    property p_rdIdle; !regRd |=> regRdata == 32'h0; endproperty
    property p_rdTop; regRd |=> regRdata[31:21] == 11'h000; endproperty
    // A trigger sets the flag, which holds off further triggers
    property p_trig0; trigger[0] |=> !trigger[0]; endproperty
    property p_trig1; trigger[1] |=> !trigger[1] [*3]; endproperty
    // Pin driven only while enabled and on
    property p_pinGate; (resultPin & ~(resultPinOe & compEnable)) == '0; endproperty
    property p_trigOn; (trigger & ~compEnable & ~$past(compEnable)) == '0; endproperty
    // Settings move only after a register write
    property p_dacHold;
        $changed(dacCode) |-> $past(regWr) || $past(regWr, 2) || $past(regWr, 3);
    endproperty
    property p_cfgHold;
        !regWr [*3] |-> $stable({compEnable, negSelect, resultPinOe, refExternal});
    endproperty

    a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
    a_rdTop: assert property (p_rdTop) else $error("upper bits not zero");
    a_trig0: assert property (p_trig0) else $error("repeat trigger ch0");
    a_trig1: assert property (p_trig1) else $error("repeat trigger ch1");
    a_pinGate: assert property (p_pinGate) else $error("pin driven while off");
    a_trigOn: assert property (p_trigOn) else $error("trigger while off");
    a_dacHold: assert property (p_dacHold) else $error("dac code moved");
    a_cfgHold: assert property (p_cfgHold) else $error("config moved");

    // Main scenarios reached
    c_trig: cover property (trigger[0]);
    c_pin: cover property (resultPin[1]);
    c_rd: cover property (regRd ##1 regRdata != 32'h0);
endmodule

bind comparator_control comparator_control_properties #(.CHANNELS(CHANNELS)) u_props
(
    .ref_clk(ref_clk), .rst(rst), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .resultPin(resultPin), .resultPinOe(resultPinOe), .compEnable(compEnable),
    .negSelect(negSelect), .trigger(trigger), .dacCode(dacCode), .refExternal(refExternal)
);

// [sim/comparator_control_tb_top.sv]
/*
 Self-checking bench for the comparator control block.
 Assumes the register port contract: read data the cycle after the strobe.
*/
`timescale 1ns/10ps
`include "comparator_cfg.svh"
module comparator_control_tb_top;
    import comparator_pkg::*;
    logic       ref_clk, rst, clkEn, regWr, regRd, refExternal, ev, res;
    addr_t      regAddr;
    word_t      regWdata, regRdata, cfg, rd;
    logic [1:0] rawResult, resultPin, resultPinOe, compEnable, posInternal, trigger;
    logic [3:0] negSelect;
    logic [4:0] dacCode;
    logic [7:0] tc0, tc1;
    int         bad_count, total_checks;

    comparator_control u_dut
    (
        .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rawResult(rawResult), .resultPin(resultPin), .resultPinOe(resultPinOe),
        .compEnable(compEnable), .posInternal(posInternal), .negSelect(negSelect),
        .trigger(trigger), .dacCode(dacCode), .refExternal(refExternal)
    );

    // Clock and trigger counters
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
    begin
        tc0 <= tc0 + 8'(trigger[0]);
        tc1 <= tc1 + 8'(trigger[1]);
    end

    task automatic chk(input word_t exp, input word_t act);
        total_checks++;
        if (act !== exp)
            begin
            bad_count++;
            $display("mismatch t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask
    task automatic wr(input addr_t a, input word_t d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdChk(input addr_t a, input word_t exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        chk(exp, regRdata);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #100000;
        bad_count++;
        summarize();
    end

    // Main sequence
    initial
    begin
        {rst, clkEn, regWr, regRd, regAddr, regWdata, rawResult} = '0;
        rst = 1'b1;
        clkEn = 1'b1;
        {tc0, tc1, bad_count, total_checks} = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdChk(`CTRL1_OFS, `CTRL_RESET);
        rdChk(`STATUS_OFS, `STATUS_RESET);
        rdChk(`DACCTRL_OFS, `DAC_RESET);
        // Edge codes, polarity and direction on both channels
        for (int code = 0; code < 4; code++)
            for (int inv = 0; inv < 2; inv++)
                for (int dir = 0; dir < 2; dir++)
                begin
                    cfg = 32'h0000_C000 | (inv << 13) | (code << 6);
                    rawResult <= {2{~dir[0]}};
                    wr(`CTRL1_OFS, cfg);
                    wr(`CTRL2_OFS, cfg);
                    repeat (8) @(posedge ref_clk);
                    wr(`CTRL1_OFS, cfg);
                    wr(`CTRL2_OFS, cfg);
                    {tc0, tc1} = '0;
                    rawResult <= {2{dir[0]}};
                    repeat (12) @(posedge ref_clk);
                    // First transition alone: only the selected direction counts
                    ev = (code == 3) || (code == 1 && dir == 1) || (code == 2 && dir == 0);
                    chk(word_t'(ev), word_t'(tc0));
                    chk(word_t'(ev), word_t'(tc1));
                    rawResult <= {2{~dir[0]}};
                    repeat (12) @(posedge ref_clk);
                    // Both directions seen: one event for any non-zero code
                    ev = (code != 0);
                    res = ~dir[0] ^ inv[0];
                    chk(32'h3, word_t'(compEnable));
                    chk(32'h3, word_t'(resultPinOe));
                    chk(word_t'(ev), word_t'(tc0));
                    chk(word_t'(ev), word_t'(tc1));
                    chk(word_t'({2{res}}), word_t'(resultPin));
                    rdChk(`CTRL1_OFS, cfg | (word_t'({ev, res}) << 8));
                    rdChk(`STATUS_OFS, word_t'({ev, ev, 14'h0, res, res}));
                end
        // Disabling drops the flag
        wr(`CTRL1_OFS, 32'h0);
        rdChk(`CTRL1_OFS, 32'h0);
        // Input selects, upper bits ignored
        for (int n = 0; n < 4; n++)
        begin
            wr(`CTRL1_OFS, 32'hFFFF_0010 | n);
            rdChk(`CTRL1_OFS, 32'h0000_0010 | n);
            chk(word_t'(n), word_t'(negSelect[1:0]));
            chk(32'h1, word_t'(posInternal[0]));
        end
        // Clear, set and invert aliases
        wr(`CTRL2_OFS, 32'h0000_0011);
        wr(`CTRL2_OFS + 8'h08, 32'h0000_2002);
        wr(`CTRL2_OFS + 8'h04, 32'h0000_0010);
        wr(`CTRL2_OFS + 8'h0C, 32'h0000_0041);
        rdChk(`CTRL2_OFS, 32'h0000_2042);
        chk(32'h2, word_t'(negSelect[3:2]));
        // DAC code, reference source, unmapped place
        wr(`DACCTRL_OFS, 32'hFFFF_FFFF);
        wr(`STATUS_OFS, 32'hFFFF_FFFF);
        wr(8'h40, 32'hFFFF_FFFF);
        rdChk(`DACCTRL_OFS, 32'h001F_0000);
        rdChk(`STATUS_OFS, 32'h0000_0100);
        rdChk(8'h40, 32'h0);
        chk(32'h3F, word_t'({refExternal, dacCode}));
        summarize();
    end
endmodule
